//--- verilog/tmr_map.svh
// register indices, field positions, reset values and codes of the timer/event counter
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH
// register indices; byte address is four times the index
`define IDX_CAPCMP_CTRL 16'hff32
`define IDX_PRESC_MODE 16'hff5e
`define IDX_TIMER_CTRL 16'hff5f
`define IDX_COUNT 16'hff10
`define IDX_CMP_A 16'hff11
`define IDX_CAPCMP_B 16'hff12
`define IDX_CAP_C 16'hff13
`define IDX_EDGE_MODE 16'hff14
// reset values
`define RST_PRESC_MODE 8'h11
`define RST_TIMER_CTRL 8'h00
`define RST_CAPCMP_CTRL 8'h00
`define RST_EDGE_MODE 2'h0
// timer_control fields
`define TC_BW 0
`define TC_OVF 2
`define TC_CE 3
// capture_compare_control fields
`define CC_CM 0
`define CC_CLR_A 3
`define CC_CLR_B 4
// prescaler_mode count clock field and codes
`define PS_LSB 0
`define PS_W 4
`define PS_DIV_MIN 4'h1
`define PS_DIV_MAX 4'h9
`define PS_EXT 4'hb
`define DIV_W 10
// edge mode codes
`define EM_W 2
`define EM_FALL 2'h0
`define EM_RISE 2'h1
`define EM_NONE 2'h2
`define EM_BOTH 2'h3
// counter limits
`define CNT_W 16
`define MAX8 16'h00ff
`define MAX16 16'hffff
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`endif

//--- verilog/tmr_pkg.sv
// state types of the timer/event counter
`include "tmr_map.svh"
package tmr_pkg;
  typedef enum logic [7:0] {
    SEL_NONE = 8'h00,
    SEL_CTRL = 8'h01,
    SEL_PRESC = 8'h02,
    SEL_CAPCMP = 8'h04,
    SEL_COUNT = 8'h08,
    SEL_CMP_A = 8'h10,
    SEL_CMP_B = 8'h20,
    SEL_CAP_C = 8'h40,
    SEL_EDGE = 8'h80
  } reg_sel_t;

  typedef struct packed {
    logic ce;
    logic ovf;
    logic bw;
    logic [7:0] presc;
    logic [7:0] capcmp;
    logic [`EM_W-1:0] edge_mode;
    logic [`CNT_W-1:0] cnt;
    logic start_pend;
    logic clr_pend;
    logic counted;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq_a;
    logic irq_b;
    logic rto_a;
    logic rto_b;
  } ctl_t;

  typedef struct packed {
    logic [`CNT_W-1:0] cmp_a;
    logic [`CNT_W-1:0] cmp_b;
    logic [`CNT_W-1:0] cap_c;
  } data_t;

  typedef struct packed {
    logic [`DIV_W-1:0] div;
    logic tick;
  } presc_st_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic pulse;
  } edge_st_t;
endpackage : tmr_pkg

//--- verilog/tmr_prescaler.sv
// prescaler and count clock selector
`timescale 1ns/1ns
`include "tmr_map.svh"
module tmr_prescaler (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // selection
  input wire logic [`PS_W-1:0] code,
  input wire logic ext_pulse,
  // count clock enable
  output logic tick
);
  import tmr_pkg::*;

  presc_st_t s;
  presc_st_t next_s;
  logic [`DIV_W:0] mask_w;

  always_comb
  begin
    next_s = s;
    mask_w = (11'h002 << code) - 11'h001;
    next_s.div = s.div + `DIV_W'(1);
    next_s.tick = 1'b0;
    // fxx/4 through fxx/1024; prohibited codes never tick
    if (code >= `PS_DIV_MIN && code <= `PS_DIV_MAX)
    begin
      next_s.tick = ((s.div & mask_w[`DIV_W-1:0]) == mask_w[`DIV_W-1:0]);
    end
    else if (code == `PS_EXT)
    begin
      next_s.tick = ext_pulse;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule : tmr_prescaler

//--- verilog/tmr_edge_detect.sv
// synchronised valid edge detector of the external input pin
`timescale 1ns/1ns
`include "tmr_map.svh"
module tmr_edge_detect (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and mode
  input wire logic ext_edge_pin,
  input wire logic [`EM_W-1:0] mode,
  // valid edge pulse
  output logic pulse
);
  import tmr_pkg::*;

  edge_st_t s;
  edge_st_t next_s;
  logic rise;
  logic fall;

  always_comb
  begin
    next_s = s;
    next_s.sync1 = ext_edge_pin;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    rise = s.sync2 & ~s.prev;
    fall = ~s.sync2 & s.prev;
    case (mode)
      `EM_FALL: next_s.pulse = fall;
      `EM_RISE: next_s.pulse = rise;
      `EM_BOTH: next_s.pulse = rise | fall;
      default: next_s.pulse = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pulse = s.pulse;
endmodule : tmr_edge_detect

//--- verilog/timer_event_counter.sv
// 8/16-bit timer/event counter with compare, capture/compare and capture registers on apb
//
// Contract
// - counter counts up on selected count clock
// - control bit 0 selects 8 or 16 bits
// - reset clears counter and stops it
// - match with compare a raises irq, trigger
// - data registers have no reset value
// - mode bit makes register b capture or compare
// - compare b match raises irq, trigger
// - capture mode latches counter into b
// - capture register latches counter every edge
// - valid edge gives irq, capture, count pulse
// - count clock is prescaler or edge pulses
// - divisions fxx/4 to fxx/1024 or external
// - low nibble governs, register resets zero; the code resets it to 8'h11 (fxx/4)
// - enable loads zero on first count clock
// - disable zeroes counter, stops capture, match
// - rewriting enable keeps counting undisturbed; the code repeats the zero load if the rewrite meets the first count clock
// - wrap at maximum sets overflow flag
// - only software clears overflow flag
// - clear enable a clears on match a
// - clear enable b clears on b event
// - 16-bit mode uses full width
// - counter, capture read-only; compares byte writable
// - clear takes effect on next count clock
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`include "tmr_map.svh"
module timer_event_counter #(
  parameter int PADDR_W = 20
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external edge input
  input wire logic ext_edge_pin,
  // events
  output logic ext_edge_irq,
  output logic match_a_irq,
  output logic match_b_irq,
  output logic rto_trigger_a,
  output logic rto_trigger_b
);
  import tmr_pkg::*;

  ctl_t s;
  ctl_t next_s;
  data_t d;
  data_t next_d;

  logic tick;
  logic edge_pulse;
  logic [`CNT_W-1:0] cmax;
  logic [`CNT_W-1:0] cnt_m;
  logic setup;
  logic access;
  logic wr_ce;
  logic ovf_set;
  logic cm;
  reg_sel_t sel;

  // reset images of the control registers; the timer control image is taken apart field by field below
  localparam logic [7:0] ctrl_rst = `RST_TIMER_CTRL;
  localparam logic [7:0] presc_rst = `RST_PRESC_MODE;
  localparam logic [7:0] capcmp_rst = `RST_CAPCMP_CTRL;

  function automatic reg_sel_t decode(input logic [PADDR_W-1:0] a);
    logic [PADDR_W-3:0] idx;
    idx = a[PADDR_W-1:2];
    if (a[1:0] != 2'h0)
      decode = SEL_NONE;
    else if (idx == (PADDR_W-2)'(`IDX_TIMER_CTRL))
      decode = SEL_CTRL;
    else if (idx == (PADDR_W-2)'(`IDX_PRESC_MODE))
      decode = SEL_PRESC;
    else if (idx == (PADDR_W-2)'(`IDX_CAPCMP_CTRL))
      decode = SEL_CAPCMP;
    else if (idx == (PADDR_W-2)'(`IDX_COUNT))
      decode = SEL_COUNT;
    else if (idx == (PADDR_W-2)'(`IDX_CMP_A))
      decode = SEL_CMP_A;
    else if (idx == (PADDR_W-2)'(`IDX_CAPCMP_B))
      decode = SEL_CMP_B;
    else if (idx == (PADDR_W-2)'(`IDX_CAP_C))
      decode = SEL_CAP_C;
    else if (idx == (PADDR_W-2)'(`IDX_EDGE_MODE))
      decode = SEL_EDGE;
    else
      decode = SEL_NONE;
  endfunction : decode

  // byte-lane merge for the 16-bit compare registers
  function automatic logic [`CNT_W-1:0] lane_merge(
    input logic [`CNT_W-1:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    lane_merge = old;
    if (strb[0])
      lane_merge[7:0] = wd[7:0];
    if (strb[1])
      lane_merge[15:8] = wd[15:8];
  endfunction : lane_merge

  // match of the moved counter against one compare register, low byte only in 8-bit mode
  function automatic logic hits(
    input logic [`CNT_W-1:0] cnt,
    input logic [`CNT_W-1:0] val,
    input logic [`CNT_W-1:0] mask
  );
    hits = (cnt & mask) == (val & mask);
  endfunction : hits

  tmr_edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .ext_edge_pin(ext_edge_pin),
    .mode(s.edge_mode),
    .pulse(edge_pulse)
  );

  tmr_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .code(s.presc[`PS_LSB +: `PS_W]),
    .ext_pulse(edge_pulse),
    .tick(tick)
  );

  always_comb
  begin
    next_s = s;
    next_d = d;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.irq_a = 1'b0;
    next_s.irq_b = 1'b0;
    next_s.rto_a = 1'b0;
    next_s.rto_b = 1'b0;
    next_s.counted = 1'b0;
    ovf_set = 1'b0;
    wr_ce = 1'b0;
    cm = s.capcmp[`CC_CM];
    cmax = s.bw ? `MAX16 : `MAX8;
    cnt_m = s.cnt & cmax;
    setup = psel & ~penable;
    access = psel & penable & s.pready;
    sel = decode(paddr);

    // counting; the counter stays at zero while stopped
    if (s.ce)
    begin
      if (tick)
      begin
        if (s.start_pend)
        begin
          next_s.cnt = `CNT_ZERO;
          next_s.start_pend = 1'b0;
          next_s.clr_pend = 1'b0;
        end
        else if (s.clr_pend)
        begin
          next_s.cnt = `CNT_ZERO;
          next_s.clr_pend = 1'b0;
          next_s.counted = 1'b1;
        end
        else if (cnt_m == cmax)
        begin
          next_s.cnt = `CNT_ZERO;
          ovf_set = 1'b1;
          next_s.counted = 1'b1;
        end
        else
        begin
          next_s.cnt = (cnt_m + `CNT_ONE) & cmax;
          next_s.counted = 1'b1;
        end
      end
      // matches are looked at only once after the counter has moved
      if (s.counted)
      begin
        if (hits(cnt_m, d.cmp_a, cmax))
        begin
          next_s.irq_a = 1'b1;
          next_s.rto_a = 1'b1;
          if (s.capcmp[`CC_CLR_A])
            next_s.clr_pend = 1'b1;
        end
        if (!cm && hits(cnt_m, d.cmp_b, cmax))
        begin
          next_s.irq_b = 1'b1;
          next_s.rto_b = 1'b1;
          if (s.capcmp[`CC_CLR_B])
            next_s.clr_pend = 1'b1;
        end
      end
    end

    // register reads are prepared in the setup cycle
    if (setup)
    begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      case (sel)
        SEL_CTRL:
        begin
          next_s.prdata[`TC_BW] = s.bw;
          next_s.prdata[`TC_OVF] = s.ovf;
          next_s.prdata[`TC_CE] = s.ce;
        end
        SEL_PRESC: next_s.prdata[7:0] = s.presc;
        SEL_CAPCMP: next_s.prdata[7:0] = s.capcmp;
        SEL_COUNT: next_s.prdata[15:0] = cnt_m;
        SEL_CMP_A: next_s.prdata[15:0] = d.cmp_a;
        SEL_CMP_B: next_s.prdata[15:0] = d.cmp_b;
        SEL_CAP_C: next_s.prdata[15:0] = d.cap_c;
        SEL_EDGE: next_s.prdata[`EM_W-1:0] = s.edge_mode;
        default: next_s.pslverr = 1'b1;
      endcase
    end

    // writes take effect on the access edge; count and capture are read-only
    if (access && pwrite)
    begin
      case (sel)
        SEL_CTRL:
        begin
          if (pstrb[0])
          begin
            wr_ce = pwdata[`TC_CE];
            next_s.bw = pwdata[`TC_BW];
            next_s.ovf = pwdata[`TC_OVF];
            next_s.ce = wr_ce;
            if (!wr_ce)
            begin
              next_s.cnt = `CNT_ZERO;
              next_s.start_pend = 1'b0;
              next_s.clr_pend = 1'b0;
              next_s.counted = 1'b0;
              next_s.irq_a = 1'b0;
              next_s.irq_b = 1'b0;
              next_s.rto_a = 1'b0;
              next_s.rto_b = 1'b0;
            end
            else if (!s.ce)
            begin
              next_s.start_pend = 1'b1;
            end
            else
            begin
              // rewriting one to a running counter keeps the count but restores start_pend; a start in that cycle repeats on the next count clock
              next_s.start_pend = s.start_pend;
            end
          end
        end
        SEL_PRESC:
        begin
          if (pstrb[0])
            next_s.presc = pwdata[7:0];
        end
        SEL_CAPCMP:
        begin
          if (pstrb[0])
            next_s.capcmp = pwdata[7:0];
        end
        SEL_CMP_A: next_d.cmp_a = lane_merge(d.cmp_a, pwdata, pstrb);
        SEL_CMP_B: next_d.cmp_b = lane_merge(d.cmp_b, pwdata, pstrb);
        SEL_EDGE:
        begin
          if (pstrb[0])
            next_s.edge_mode = pwdata[`EM_W-1:0];
        end
        default:
        begin
          next_s.edge_mode = next_s.edge_mode;
        end
      endcase
    end

    // a capture beats a software write to register b in the same cycle,
    // but a disable written in that cycle wins and no capture is taken
    if (s.ce && next_s.ce && edge_pulse)
    begin
      next_d.cap_c = cnt_m;
      if (cm)
      begin
        next_d.cmp_b = cnt_m;
        if (s.capcmp[`CC_CLR_B])
          next_s.clr_pend = 1'b1;
      end
    end

    // a wrap beats a software clear of the flag
    if (ovf_set)
      next_s.ovf = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.ce <= ctrl_rst[`TC_CE];
      s.ovf <= ctrl_rst[`TC_OVF];
      s.bw <= ctrl_rst[`TC_BW];
      s.presc <= presc_rst;
      s.capcmp <= capcmp_rst;
      s.edge_mode <= `RST_EDGE_MODE;
      s.cnt <= `CNT_ZERO;
    end
    else
    begin
      s <= next_s;
    end
  end

  // compare and capture data keep no reset, software must load the compare registers
  always_ff @(posedge pclk)
  begin
    d <= next_d;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign ext_edge_irq = edge_pulse;
  assign match_a_irq = s.irq_a;
  assign match_b_irq = s.irq_b;
  assign rto_trigger_a = s.rto_a;
  assign rto_trigger_b = s.rto_b;
endmodule : timer_event_counter

//--- sim/tmr_props.sv
// assertion checker on the timer/event counter ports
`timescale 1ns/1ns
module tmr_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pin and events
  input wire logic ext_edge_pin,
  input wire logic ext_edge_irq,
  input wire logic match_a_irq,
  input wire logic match_b_irq,
  input wire logic rto_trigger_a,
  input wire logic rto_trigger_b
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_ta; match_a_irq == rto_trigger_a; endproperty
  a_ta: assert property (p_ta) else $error("trigger a");
  property p_tb; match_b_irq == rto_trigger_b; endproperty
  a_tb: assert property (p_tb) else $error("trigger b");
  property p_apl; match_a_irq |=> !match_a_irq; endproperty
  a_apl: assert property (p_apl) else $error("long match");
  // pin levels are held long, so a pulse needs one pin change in the window
  property p_edg; ext_edge_irq |-> $past(ext_edge_pin) != $past(ext_edge_pin, 7); endproperty
  a_edg: assert property (p_edg) else $error("edge no cause");
  property p_epl; ext_edge_irq |=> !ext_edge_irq; endproperty
  a_epl: assert property (p_epl) else $error("long edge");
endmodule : tmr_props
bind timer_event_counter tmr_props p_u (.pclk, .presetn, .psel, .penable, .prdata, .pready,
  .pslverr, .ext_edge_pin, .ext_edge_irq, .match_a_irq, .match_b_irq, .rto_trigger_a,
  .rto_trigger_b);

//--- sim/edge_src.sv
// model of the source driving the external edge pin
`timescale 1ns/1ns
module edge_src (
  // clock
  input wire logic pclk,
  // toggle request
  input wire logic go,
  // pin
  output logic pin
);
  initial pin = 1'b0;
  always @(posedge pclk)
    if (go)
      pin <= ~pin;
endmodule : edge_src

//--- sim/tb.sv
// self-checking testbench of the timer/event counter
`timescale 1ns/1ns
`include "tmr_map.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [19:0] paddr = 20'h0;
  logic [3:0] pstrb = 4'h3;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, pin, e, irq_e, irq_a, irq_b;
  int errors = 0, n_compared = 0, na = 0, nb = 0, ne = 0, t1;
  always #25 pclk = ~pclk;
  // counts lag one cycle but never race the scenario code
  always @(posedge pclk)
  begin
    na <= na + int'(irq_a);
    nb <= nb + int'(irq_b);
    ne <= ne + int'(irq_e);
  end
  timer_event_counter dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .ext_edge_pin(pin), .ext_edge_irq(irq_e),
    .match_a_irq(irq_a), .match_b_irq(irq_b), .rto_trigger_a(), .rto_trigger_b());
  edge_src src_u (.pclk, .go, .pin);
  task automatic ck(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, g, x);
    end
  endtask : ck
  task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask : wr
  task automatic rd(input logic [15:0] i, input logic [31:0] x);
    apb(1'b0, i, 32'h0);
    ck(q, x);
  endtask : rd
  task automatic wt(ref int c, input int n);
    repeat (3000)
      if (c < n)
        @(posedge pclk);
    if (c < n)
    begin
      errors++;
      $display("Error %0t: wait for event ran out", $time);
    end
  endtask : wt
  // ten cycles a level keeps every edge visible to the synchroniser
  task automatic tog;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (9) @(posedge pclk);
  endtask : tog
  task automatic s_reset;
    rd(`IDX_TIMER_CTRL, 32'h0);
    rd(`IDX_PRESC_MODE, 32'h11);
    rd(`IDX_CAPCMP_CTRL, 32'h0);
    rd(`IDX_COUNT, 32'h0);
  endtask : s_reset
  task automatic s_access;
    apb(1'b0, 16'hff00, 32'h0);
    ck({31'h0, e}, 32'h1);
    wr(`IDX_COUNT, 32'h55);
    rd(`IDX_COUNT, 32'h0);
    wr(`IDX_CAPCMP_B, 32'h1234);
    rd(`IDX_CAPCMP_B, 32'h1234);
    pstrb <= 4'h2;
    wr(`IDX_CAPCMP_B, 32'hab00);
    pstrb <= 4'h3;
    rd(`IDX_CAPCMP_B, 32'hab34);
  endtask : s_access
  task automatic s_clear_a;
    wr(`IDX_PRESC_MODE, 32'h1);
    wr(`IDX_CMP_A, 32'h5);
    wr(`IDX_CAPCMP_CTRL, 32'h8);
    wr(`IDX_TIMER_CTRL, 32'h8);
    wt(na, 1);
    t1 = int'($time);
    wr(`IDX_TIMER_CTRL, 32'h8);
    wt(na, 2);
    ck(int'($time) - t1, 1200);
    wr(`IDX_TIMER_CTRL, 32'h0);
    rd(`IDX_COUNT, 32'h0);
    repeat (60) @(posedge pclk);
    ck(na, 2);
  endtask : s_clear_a
  task automatic s_overflow;
    wr(`IDX_CAPCMP_CTRL, 32'h0);
    wr(`IDX_CMP_A, 32'h105);
    wr(`IDX_TIMER_CTRL, 32'h8);
    repeat (1100) @(posedge pclk);
    ck(na > 2, 1);
    rd(`IDX_TIMER_CTRL, 32'hc);
    wr(`IDX_TIMER_CTRL, 32'h8);
    rd(`IDX_TIMER_CTRL, 32'h8);
  endtask : s_overflow
  task automatic s_wide;
    wr(`IDX_TIMER_CTRL, 32'h0);
    wr(`IDX_TIMER_CTRL, 32'h9);
    t1 = na;
    repeat (400) @(posedge pclk);
    ck(na, t1);
    wt(na, t1 + 1);
    apb(1'b0, `IDX_COUNT, 32'h0);
    ck(q[15:8], 32'h1);
    wr(`IDX_TIMER_CTRL, 32'h0);
  endtask : s_wide
  task automatic s_capture;
    wr(`IDX_EDGE_MODE, 32'h1);
    wr(`IDX_CAPCMP_CTRL, 32'h1);
    wr(`IDX_TIMER_CTRL, 32'h8);
    repeat (40) @(posedge pclk);
    tog;
    ck(ne, 1);
    apb(1'b0, `IDX_CAP_C, 32'h0);
    t1 = int'(q);
    ck(t1 > 5 && t1 < 16, 1);
    rd(`IDX_CAPCMP_B, t1);
    tog;
    ck(ne, 1);
    rd(`IDX_CAP_C, t1);
  endtask : s_capture
  task automatic s_external;
    wr(`IDX_TIMER_CTRL, 32'h0);
    wr(`IDX_PRESC_MODE, 32'hb);
    wr(`IDX_EDGE_MODE, 32'h3);
    wr(`IDX_CAPCMP_CTRL, 32'h0);
    wr(`IDX_CAPCMP_B, 32'h3);
    t1 = nb;
    wr(`IDX_TIMER_CTRL, 32'h8);
    repeat (5) tog;
    rd(`IDX_COUNT, 32'h4);
    ck(nb, t1 + 1);
  endtask : s_external
  task automatic conclude;
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_access;
    s_clear_a;
    s_overflow;
    s_wide;
    s_capture;
    s_external;
    conclude;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    conclude;
  end
endmodule : tb
